// *** design/ifd_defs.vh ***
/*
  Constants for the input function decoder: function codes, register
  offsets, status field positions, reset values and timing figures.
  Assumes inclusion by bare name from the design files.
*/
// How it works
// - rising edge on code 1 starts program numbered BCD from bits 9..15
// - rising edge on code 2 starts program numbered binary from bits 9..15
// - codes 1 and 2 assigned together is a configuration error
// - code 3 soft resets after one second held; host holds it that long
// - code 4 rising edge servos on all axes, falling edge servos off
// - code 5 rising starts auto program, falling aborts all operations
// - code 6 low, servo-off inactive, holds operations in auto mode
// - code 6 asserted outside auto mode aborts operations instead
// - code 8 low pauses operation, only during auto mode
// - pause stays latched until rising edge on code 7
// - program bits must be assigned contiguously upward from code 9
// - program bits 1, 2, 3 weigh 1, 2, 4 in both codings
// - bits 5, 6, 7 weigh 16, 32, 64 binary and 10, 20, 40 BCD
// - code 16 rising edge clears errors
`ifndef IFD_DEFS_VH
`define IFD_DEFS_VH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define IFD_NPORTS 32
`define IFD_CW 5
`define IFD_AW 6
`define IFD_DW 32
`define IFD_NFN 17

// ----------------------------------------------------------------
// function codes
// ----------------------------------------------------------------
`define IFD_FN_GP 5'h00
`define IFD_FN_START_BCD 5'h01
`define IFD_FN_START_BIN 5'h02
`define IFD_FN_SOFT_RST 5'h03
`define IFD_FN_SERVO 5'h04
`define IFD_FN_AUTO 5'h05
`define IFD_FN_ILOCK 5'h06
`define IFD_FN_PAUSE_CLR 5'h07
`define IFD_FN_PAUSE 5'h08
`define IFD_FN_PBIT0 5'h09
`define IFD_FN_PBIT6 5'h0f
`define IFD_FN_ERR_RST 5'h10

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define IFD_OFF_FUNC_LAST 6'h1f
`define IFD_OFF_STATUS 6'h20
`define IFD_OFF_PINS 6'h21
`define IFD_OFF_PROG 6'h22

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define IFD_ST_ERR_BOTH 0
`define IFD_ST_ERR_ORDER 1
`define IFD_ST_PAUSE 2
`define IFD_ST_HOLD 3
`define IFD_ST_SERVO_OFF 4
`define IFD_ST_AUTO 5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define IFD_RST_CODE 5'h00
`define IFD_RST_PROG 8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define IFD_CLK_KHZ 50000
`define IFD_TICK_MS 1
`define IFD_SOFT_RST_MS 1000

`endif

// *** design/ifd_func_map.v ***
/*
  Function code store: one code per input port, held in flip-flops and
  offered all at once for parallel decode.
  Assumes a single clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ifd_defs.vh"

module ifd_func_map #(
  parameter NPORTS = `IFD_NPORTS,
  parameter CW = `IFD_CW
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // write port
  input wire wr_en,
  input wire [4:0] wr_idx,
  input wire [CW-1:0] wr_code,
  // all codes
  output wire [NPORTS*CW-1:0] codes_flat
);

  genvar i;
  generate
    for (i = 0; i < NPORTS; i = i + 1) begin : g_ent
      reg [CW-1:0] code_ff;
      always @(posedge clk) begin
        if (rst) begin
          code_ff <= `IFD_RST_CODE;
        end else if (wr_en && (wr_idx == i)) begin
          code_ff <= wr_code;
        end
      end
      assign codes_flat[i*CW +: CW] = code_ff;
    end
  endgenerate

endmodule
`default_nettype wire

// *** design/ifd_input_decoder.v ***
/*
  Input function decoder: each discrete input port is given a function
  code by software; the synced port levels are folded per function and
  their edges and levels become action pulses and hold/pause levels.
  Assumes the ports are asynchronous pins, auto_mode comes from logic on
  clk, and reset is synchronous active high.
*/
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ifd_defs.vh"

module ifd_input_decoder #(
  parameter NPORTS = `IFD_NPORTS,
  parameter TICK_CYCLES = `IFD_CLK_KHZ * `IFD_TICK_MS,
  parameter SOFT_RST_TICKS = `IFD_SOFT_RST_MS / `IFD_TICK_MS
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // discrete input pins
  input wire [NPORTS-1:0] pin_in,
  // controller mode
  input wire auto_mode,
  // register port
  input wire [`IFD_AW-1:0] reg_addr,
  input wire [`IFD_DW-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`IFD_DW-1:0] reg_rdata_ff,
  // program start
  output reg prog_start_ff,
  output reg [7:0] prog_num_ff,
  // action pulses
  output reg soft_reset_ff,
  output reg servo_on_ff,
  output reg servo_off_ff,
  output reg auto_start_ff,
  output reg abort_all_ff,
  output reg err_reset_ff,
  // levels
  output reg op_hold_ff,
  output reg op_pause_ff,
  output reg cfg_error_ff
);

  localparam CW = `IFD_CW;
  localparam NFN = `IFD_NFN;
  localparam TW = $clog2(TICK_CYCLES + 1);
  localparam SW = $clog2(SOFT_RST_TICKS + 2);
  localparam integer TICK_LAST_I = TICK_CYCLES - 1;
  localparam integer SRT_LAST_I = SOFT_RST_TICKS;
  localparam [TW-1:0] TICK_LAST = TICK_LAST_I[TW-1:0];
  localparam [SW-1:0] SRT_LAST = SRT_LAST_I[SW-1:0];

  // ----------------------------------------------------------------
  // function code store
  // ----------------------------------------------------------------
  wire [NPORTS*CW-1:0] codes_flat;
  wire map_wr;

  assign map_wr = reg_wr && (reg_addr <= `IFD_OFF_FUNC_LAST);

  ifd_func_map #(
    .NPORTS(NPORTS),
    .CW(CW)
  ) u_map (
    .clk(clk),
    .rst(rst),
    .wr_en(map_wr),
    .wr_idx(reg_addr[4:0]),
    .wr_code(reg_wdata[CW-1:0]),
    .codes_flat(codes_flat)
  );

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  reg [NPORTS-1:0] sync1_ff;
  reg [NPORTS-1:0] sync2_ff;

  always @(posedge clk) begin
    if (rst) begin
      sync1_ff <= {NPORTS{1'b0}};
      sync2_ff <= {NPORTS{1'b0}};
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
    end
  end

  // ----------------------------------------------------------------
  // per function fold of port levels
  // ----------------------------------------------------------------
  wire [NFN*NPORTS-1:0] match;
  wire [NFN*NPORTS-1:0] hit_hi;
  wire [NFN*NPORTS-1:0] hit_lo;
  wire [NFN-1:0] asg;
  wire [NFN-1:0] act;

  genvar k;
  genvar p;
  generate
    for (k = 0; k < NFN; k = k + 1) begin : g_fn
      for (p = 0; p < NPORTS; p = p + 1) begin : g_port
        assign match[k*NPORTS+p] = (codes_flat[p*CW +: CW] == k);
        assign hit_hi[k*NPORTS+p] = match[k*NPORTS+p] & sync2_ff[p];
        assign hit_lo[k*NPORTS+p] = match[k*NPORTS+p] & ~sync2_ff[p];
      end
      assign asg[k] = |match[k*NPORTS +: NPORTS];
      // interlock and pause are active while their port is low
      if ((k == `IFD_FN_ILOCK) || (k == `IFD_FN_PAUSE)) begin : g_low
        assign act[k] = |hit_lo[k*NPORTS +: NPORTS];
      end else begin : g_high
        assign act[k] = |hit_hi[k*NPORTS +: NPORTS];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  reg [NFN-1:0] act_prev_ff;
  wire [NFN-1:0] rise;
  wire [NFN-1:0] fall;

  always @(posedge clk) begin
    if (rst) begin
      act_prev_ff <= {NFN{1'b0}};
    end else begin
      act_prev_ff <= act;
    end
  end

  assign rise = act & ~act_prev_ff;
  assign fall = ~act & act_prev_ff;

  // ----------------------------------------------------------------
  // configuration checks
  // ----------------------------------------------------------------
  wire [6:0] pb_asg;
  wire [7:0] pb_asg_inc;
  wire err_both;
  wire err_order;
  wire start_ok;

  assign pb_asg = asg[`IFD_FN_PBIT6:`IFD_FN_PBIT0];
  assign pb_asg_inc = {1'b0, pb_asg} + 8'h01;
  assign err_both = asg[`IFD_FN_START_BCD] & asg[`IFD_FN_START_BIN];
  assign err_order = ((pb_asg_inc[6:0] & pb_asg) != 7'h00);
  assign start_ok = ~err_both & ~err_order;

  // ----------------------------------------------------------------
  // program number
  // ----------------------------------------------------------------
  wire [6:0] pb;
  wire [7:0] num_bin;
  wire [7:0] num_bcd;

  assign pb = act[`IFD_FN_PBIT6:`IFD_FN_PBIT0];
  assign num_bin = {1'b0, pb};
  assign num_bcd = {4'h0, pb[3:0]} + (pb[4] ? 8'h0a : 8'h00) + (pb[5] ? 8'h14 : 8'h00) +
                   (pb[6] ? 8'h28 : 8'h00);

  always @(posedge clk) begin
    if (rst) begin
      prog_start_ff <= 1'b0;
      prog_num_ff <= `IFD_RST_PROG;
    end else begin
      prog_start_ff <= 1'b0;
      if (start_ok && rise[`IFD_FN_START_BCD]) begin
        prog_start_ff <= 1'b1;
        prog_num_ff <= num_bcd;
      end else if (start_ok && rise[`IFD_FN_START_BIN]) begin
        prog_start_ff <= 1'b1;
        prog_num_ff <= num_bin;
      end
    end
  end

  // ----------------------------------------------------------------
  // millisecond tick
  // ----------------------------------------------------------------
  reg [TW-1:0] tick_cnt_ff;
  reg tick_ff;

  always @(posedge clk) begin
    if (rst) begin
      tick_cnt_ff <= {TW{1'b0}};
      tick_ff <= 1'b0;
    end else if (tick_cnt_ff == TICK_LAST) begin
      tick_cnt_ff <= {TW{1'b0}};
      tick_ff <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + {{(TW-1){1'b0}}, 1'b1};
      tick_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // soft reset hold timer
  // ----------------------------------------------------------------
  reg [SW-1:0] srt_cnt_ff;
  reg srt_done_ff;

  always @(posedge clk) begin
    if (rst) begin
      srt_cnt_ff <= {SW{1'b0}};
      srt_done_ff <= 1'b0;
      soft_reset_ff <= 1'b0;
    end else if (!act[`IFD_FN_SOFT_RST]) begin
      srt_cnt_ff <= {SW{1'b0}};
      srt_done_ff <= 1'b0;
      soft_reset_ff <= 1'b0;
    end else begin
      soft_reset_ff <= 1'b0;
      if (tick_ff && !srt_done_ff) begin
        if (srt_cnt_ff == SRT_LAST) begin
          soft_reset_ff <= 1'b1;
          srt_done_ff <= 1'b1;
        end else begin
          srt_cnt_ff <= srt_cnt_ff + {{(SW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // servo, auto start, interlock, pause
  // ----------------------------------------------------------------
  reg servo_off_cmd_ff;
  reg ilk_abort_prev_ff;
  wire ilk_en;
  wire ilk_abort;

  // only while servo off not active
  assign ilk_en = act[`IFD_FN_ILOCK] & ~servo_off_cmd_ff;
  assign ilk_abort = ilk_en & ~auto_mode;

  always @(posedge clk) begin
    if (rst) begin
      servo_on_ff <= 1'b0;
      servo_off_ff <= 1'b0;
      servo_off_cmd_ff <= 1'b0;
      auto_start_ff <= 1'b0;
      abort_all_ff <= 1'b0;
      err_reset_ff <= 1'b0;
      op_hold_ff <= 1'b0;
      op_pause_ff <= 1'b0;
      ilk_abort_prev_ff <= 1'b0;
      cfg_error_ff <= 1'b0;
    end else begin
      servo_on_ff <= rise[`IFD_FN_SERVO];
      servo_off_ff <= fall[`IFD_FN_SERVO];
      if (fall[`IFD_FN_SERVO]) begin
        servo_off_cmd_ff <= 1'b1;
      end else if (rise[`IFD_FN_SERVO]) begin
        servo_off_cmd_ff <= 1'b0;
      end
      auto_start_ff <= rise[`IFD_FN_AUTO];
      abort_all_ff <= fall[`IFD_FN_AUTO] | (ilk_abort & ~ilk_abort_prev_ff);
      ilk_abort_prev_ff <= ilk_abort;
      op_hold_ff <= ilk_en & auto_mode;
      // latched until reset edge, set wins
      op_pause_ff <= (act[`IFD_FN_PAUSE] & auto_mode) |
                     (op_pause_ff & ~rise[`IFD_FN_PAUSE_CLR]);
      err_reset_ff <= rise[`IFD_FN_ERR_RST];
      cfg_error_ff <= ~start_ok;
    end
  end

  // ----------------------------------------------------------------
  // pin word for the register port
  // ----------------------------------------------------------------
  wire [`IFD_DW-1:0] pins_word;

  // pads unused upper bits so any port count up to 32 fits the data word
  genvar q;
  generate
    for (q = 0; q < `IFD_DW; q = q + 1) begin : g_pw
      if (q < NPORTS) begin : g_pin
        assign pins_word[q] = sync2_ff[q];
      end else begin : g_pad
        assign pins_word[q] = 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  wire [`IFD_DW-1:0] status_word;
  reg [CW-1:0] rd_code;
  integer j;

  assign status_word = {26'h0000000, auto_mode, servo_off_cmd_ff, op_hold_ff, op_pause_ff,
                        err_order, err_both};

  always @* begin
    rd_code = {CW{1'b0}};
    for (j = 0; j < NPORTS; j = j + 1) begin
      if (reg_addr[4:0] == j) begin
        rd_code = codes_flat[j*CW +: CW];
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      reg_rdata_ff <= {`IFD_DW{1'b0}};
    end else if (reg_rd) begin
      if (reg_addr <= `IFD_OFF_FUNC_LAST) begin
        reg_rdata_ff <= {{(`IFD_DW-CW){1'b0}}, rd_code};
      end else if (reg_addr == `IFD_OFF_STATUS) begin
        reg_rdata_ff <= status_word;
      end else if (reg_addr == `IFD_OFF_PINS) begin
        reg_rdata_ff <= pins_word;
      end else if (reg_addr == `IFD_OFF_PROG) begin
        reg_rdata_ff <= {24'h000000, prog_num_ff};
      end else begin
        reg_rdata_ff <= {`IFD_DW{1'b0}};
      end
    end else begin
      reg_rdata_ff <= {`IFD_DW{1'b0}};
    end
  end

endmodule
`default_nettype wire

// *** tb/ifd_chk_asserts.sv ***
/*
  Port checker for the input decoder.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ifd_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // inputs
  input wire logic auto_mode,
  input wire logic reg_rd,
  // outputs
  input wire logic [31:0] reg_rdata_ff,
  input wire logic prog_start_ff,
  input wire logic [7:0] prog_num_ff,
  input wire logic soft_reset_ff,
  input wire logic servo_on_ff,
  input wire logic servo_off_ff,
  input wire logic auto_start_ff,
  input wire logic abort_all_ff,
  input wire logic err_reset_ff,
  input wire logic op_pause_ff,
  input wire logic cfg_error_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_ff == 32'h0) else $error("read data outside window");
  a_servo_excl: assert property (!(servo_on_ff && servo_off_ff)) else $error("servo on and off together");
  a_servo_pulse: assert property (servo_on_ff |=> !servo_on_ff) else $error("servo on pulse too long");
  a_start_cfg: assert property (prog_start_ff |-> !cfg_error_ff) else $error("start during config error");
  a_num_start: assert property ($changed(prog_num_ff) |-> prog_start_ff) else $error("number moved without start");
  a_soft_once: assert property (soft_reset_ff |=> !soft_reset_ff [*8]) else $error("soft reset repeated");
  a_auto_pulse: assert property (auto_start_ff |=> !auto_start_ff) else $error("auto start pulse too long");
  a_pause_auto: assert property ($rose(op_pause_ff) |-> $past(auto_mode)) else $error("pause outside auto");
  a_err_pulse: assert property (err_reset_ff |=> !err_reset_ff) else $error("error reset pulse too long");
  a_abort_pulse: assert property (abort_all_ff |=> !abort_all_ff) else $error("abort pulse too long");
  c_start: cover property (prog_start_ff);
  c_soft: cover property (soft_reset_ff);
  c_pause: cover property (op_pause_ff);
endmodule
bind ifd_input_decoder ifd_chk u_chk (.clk(clk), .rst(rst), .auto_mode(auto_mode), .reg_rd(reg_rd),
  .reg_rdata_ff(reg_rdata_ff), .prog_start_ff(prog_start_ff), .prog_num_ff(prog_num_ff),
  .soft_reset_ff(soft_reset_ff), .servo_on_ff(servo_on_ff), .servo_off_ff(servo_off_ff),
  .auto_start_ff(auto_start_ff), .abort_all_ff(abort_all_ff), .err_reset_ff(err_reset_ff),
  .op_pause_ff(op_pause_ff), .cfg_error_ff(cfg_error_ff));
`default_nettype wire

// *** tb/ifd_host_model.sv ***
/*
  Host model: drives the discrete input pins.
  Assumes the decoder clock; the caller lets it settle between changes.
*/
`timescale 1ns/1ps
`default_nettype none
module ifd_host_model #(
  parameter HOLD = 12
) (
  // clock
  input wire logic clk,
  // pins
  output var logic [31:0] pins
);
  // low-active inputs idle high
  initial pins = 32'h000000a0;
  task automatic drive(input logic [31:0] v);
    @(posedge clk);
    pins <= v;
  endtask
  task automatic settle();
    repeat (HOLD) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** tb/input_function_decoder_bench.sv ***
/*
  Self-checking bench for the input decoder.
  Assumes the host model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module input_function_decoder_bench;
  typedef struct packed {logic bin; logic [6:0] bits; logic [7:0] num;} ifd_row_t;
  logic clk, rst, auto_mode, reg_wr, reg_rd;
  logic [5:0] reg_addr;
  logic [31:0] reg_wdata, pins_v;
  wire [31:0] pin_in, reg_rdata_ff;
  wire [7:0] prog_num_ff;
  wire prog_start_ff, soft_reset_ff, servo_on_ff, servo_off_ff, auto_start_ff, abort_all_ff;
  wire err_reset_ff, op_hold_ff, op_pause_ff, cfg_error_ff;
  wire [6:0] pulses = {prog_start_ff, soft_reset_ff, servo_on_ff, servo_off_ff, auto_start_ff, abort_all_ff,
    err_reset_ff};
  int mismatches = 0, tests_run = 0, cycles = 0, n;
  ifd_row_t rows [9] = '{'{0, 7'h01, 8'd1}, '{0, 7'h0f, 8'd15}, '{0, 7'h10, 8'd10}, '{0, 7'h7f, 8'd85},
    '{0, 7'h55, 8'd55}, '{0, 7'h40, 8'd40}, '{1, 7'h7f, 8'h7f}, '{1, 7'h2a, 8'h2a}, '{1, 7'h01, 8'h01}};
  ifd_host_model u_host (.clk(clk), .pins(pin_in));
  ifd_input_decoder #(.TICK_CYCLES(10), .SOFT_RST_TICKS(4)) u_dut (.clk(clk), .rst(rst), .pin_in(pin_in),
    .auto_mode(auto_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff), .prog_start_ff(prog_start_ff), .prog_num_ff(prog_num_ff),
    .soft_reset_ff(soft_reset_ff), .servo_on_ff(servo_on_ff), .servo_off_ff(servo_off_ff),
    .auto_start_ff(auto_start_ff), .abort_all_ff(abort_all_ff), .err_reset_ff(err_reset_ff),
    .op_hold_ff(op_hold_ff), .op_pause_ff(op_pause_ff), .cfg_error_ff(cfg_error_ff));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic end_of_test();
    if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata_ff, e);
  endtask
  // pin change, then pulses checked 3 cycles on
  task automatic act(input int p, input logic b, input logic [6:0] e);
    pins_v[p] = b;
    u_host.drive(pins_v);
    repeat (3) @(posedge clk);
    #1;
    chk(pulses, e);
    u_host.settle();
  endtask
  task automatic wait_soft(input int lim);
    n = 0;
    while (soft_reset_ff !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    rst = 1'b1;
    auto_mode = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 32'h0;
    pins_v = 32'h000000a0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(6'h20, 32'h0);
    rd(6'h00, 32'h0);
    rd(6'h3f, 32'h0);
    wr(6'h20, 32'hff);
    rd(6'h20, 32'h0);
    for (int i = 2; i < 8; i++) wr(6'(i), 32'(i + 1));
    wr(6'h08, 32'h10);
    for (int i = 9; i < 16; i++) wr(6'(i), 32'(i));
    rd(6'h08, 32'h10);
    rd(6'h21, 32'ha0);
    foreach (rows[i]) begin
      wr(6'h00, rows[i].bin ? 32'h2 : 32'h1);
      pins_v[15:9] = rows[i].bits;
      act(0, 1'b0, 7'h00);
      act(0, 1'b1, 7'h40);
      chk(prog_num_ff, rows[i].num);
      rd(6'h22, 32'(rows[i].num));
      act(0, 1'b0, 7'h00);
    end
    wr(6'h00, 32'h1);
    wr(6'h01, 32'h2);
    rd(6'h20, 32'h1);
    chk(cfg_error_ff, 1'b1);
    act(0, 1'b1, 7'h00);
    act(0, 1'b0, 7'h00);
    wr(6'h01, 32'h0);
    wr(6'h09, 32'h0);
    rd(6'h20, 32'h2);
    wr(6'h09, 32'h9);
    rd(6'h20, 32'h0);
    act(3, 1'b1, 7'h10);
    act(3, 1'b0, 7'h08);
    rd(6'h20, 32'h10);
    act(5, 1'b0, 7'h00);
    chk(op_hold_ff, 1'b0);
    act(5, 1'b1, 7'h00);
    act(3, 1'b1, 7'h10);
    act(5, 1'b0, 7'h02);
    chk(op_hold_ff, 1'b0);
    act(5, 1'b1, 7'h00);
    @(posedge clk);
    auto_mode <= 1'b1;
    act(5, 1'b0, 7'h00);
    chk(op_hold_ff, 1'b1);
    act(5, 1'b1, 7'h00);
    chk(op_hold_ff, 1'b0);
    act(4, 1'b1, 7'h04);
    act(4, 1'b0, 7'h02);
    act(7, 1'b0, 7'h00);
    chk(op_pause_ff, 1'b1);
    act(7, 1'b1, 7'h00);
    chk(op_pause_ff, 1'b1);
    rd(6'h20, 32'h24);
    act(6, 1'b1, 7'h00);
    chk(op_pause_ff, 1'b0);
    act(6, 1'b0, 7'h00);
    @(posedge clk);
    auto_mode <= 1'b0;
    act(7, 1'b0, 7'h00);
    chk(op_pause_ff, 1'b0);
    act(7, 1'b1, 7'h00);
    act(8, 1'b1, 7'h01);
    act(8, 1'b0, 7'h00);
    pins_v[2] = 1'b1;
    u_host.drive(pins_v);
    wait_soft(30);
    pins_v[2] = 1'b0;
    u_host.drive(pins_v);
    chk(n, 30);
    u_host.settle();
    pins_v[2] = 1'b1;
    u_host.drive(pins_v);
    wait_soft(100);
    chk(n >= 38 && n <= 58, 1'b1);
    @(posedge clk);
    #1;
    wait_soft(80);
    chk(n, 80);
    act(2, 1'b0, 7'h00);
    // mid-run reset clears outputs, codes and status
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({pulses, op_hold_ff, op_pause_ff, cfg_error_ff, prog_num_ff}, 32'h0);
    rd(6'h03, 32'h0);
    rd(6'h20, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
